// >>> bench/occ_osc_ctrl_asserts.sv
`timescale 1ns/1ps
module occ_osc_ctrl_asserts
  import occ_pkg::*;
#(
  parameter int OST_COUNT = OCC_OST_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Read channels
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  // Oscillator status and controls
  input wire logic cfg_pll_force,
  input wire logic sec_osc_enable,
  input wire logic sec_osc_raw_ready,
  input wire logic pll_ready,
  input wire logic hf_osc_ready,
  input wire logic hf_osc_locked,
  input wire logic mf_osc_ready,
  input wire logic lf_osc_ready,
  input wire logic hf_osc_stable,
  input wire logic pll_enable,
  input wire logic [1:0] clk_source,
  input wire logic [1:0] int_osc_id,
  input wire logic [3:0] int_freq_div_code
);
  logic [3:0] ar_q;
  logic [7:0] st_q;
  // Status is captured at the request edge, as the read data is.
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      ar_q <= s_axi_araddr;
      st_q <= {!sec_osc_enable || sec_osc_raw_ready, pll_ready,
        clk_source == OCC_SRC_CFG, hf_osc_ready, hf_osc_locked,
        mf_osc_ready, lf_osc_ready, hf_osc_stable};
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_pll_forced: assert property (cfg_pll_force |-> pll_enable)
    else $error("PLL off while forced.");
  a_reset_freq: assert property (disable iff (1'b0)
    !aresetn |=> int_freq_div_code == OCC_IFS_RESET)
    else $error("Frequency select not reset.");
  a_osc_lf: assert property (int_freq_div_code[3:1] == 3'h0
    |-> int_osc_id == OCC_OSC_LF) else $error("LF decode wrong.");
  a_osc_hf: assert property (int_freq_div_code[3]
    || int_freq_div_code == 4'h3 |-> int_osc_id == OCC_OSC_HF)
    else $error("HF decode wrong.");
  a_osc_mf: assert property (!int_freq_div_code[3]
    && int_freq_div_code[2:1] != 2'h0 && int_freq_div_code != 4'h3
    |-> int_osc_id == OCC_OSC_MF) else $error("MF decode wrong.");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("Read answer late.");
  a_status_read: assert property ($rose(s_axi_rvalid)
    && ar_q == OCC_ADDR_STATUS |-> s_axi_rdata == {24'h0, st_q})
    else $error("Status read wrong.");
  a_unmapped_read: assert property ($rose(s_axi_rvalid) && ar_q == 4'hc
    |-> s_axi_rresp == OCC_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("Unmapped read wrong.");
  c_status: cover property ($rose(s_axi_rvalid) && ar_q == OCC_ADDR_STATUS);
  c_forced: cover property (cfg_pll_force && pll_enable);
  c_second: cover property (clk_source == OCC_SRC_SEC);
endmodule

bind occ_osc_ctrl occ_osc_ctrl_asserts #(.OST_COUNT(OST_COUNT)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .cfg_pll_force(cfg_pll_force),
  .sec_osc_enable(sec_osc_enable), .sec_osc_raw_ready(sec_osc_raw_ready),
  .pll_ready(pll_ready), .hf_osc_ready(hf_osc_ready),
  .hf_osc_locked(hf_osc_locked), .mf_osc_ready(mf_osc_ready),
  .lf_osc_ready(lf_osc_ready), .hf_osc_stable(hf_osc_stable),
  .pll_enable(pll_enable), .clk_source(clk_source),
  .int_osc_id(int_osc_id), .int_freq_div_code(int_freq_div_code));

// >>> bench/tb.sv
`timescale 1ns/1ps
module tb;
  import occ_pkg::*;
  localparam logic [7:0] PAT [4] = '{8'h5a, 8'ha5, 8'h3f, 8'hc0};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic cfg_pll_force = 0, cfg_crystal_mode = 0;
  logic pll_enable, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, clk_source, int_osc_id, rr, br;
  // Event pins: bit 0 tick, bit 1 wake, bit 2 clock fail, bit 3 sleep.
  logic [3:0] ev = 4'h0;
  logic [7:0] st = 8'h00;
  logic [3:0] int_freq_div_code;
  logic [5:0] freq_trim;
  int errors = 0, samples_checked = 0, cyc = 0;
  always #2 aclk = ~aclk;
  // A short start-up count keeps the crystal case brief.
  occ_osc_ctrl #(.OST_COUNT(4)) DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .cfg_pll_force(cfg_pll_force),
    .cfg_osc_mode(3'h0), .cfg_crystal_mode(cfg_crystal_mode),
    .sec_osc_enable(st[7]), .sec_osc_raw_ready(st[6]),
    .pll_ready(st[5]), .hf_osc_ready(st[4]), .hf_osc_locked(st[3]),
    .mf_osc_ready(st[2]), .lf_osc_ready(st[1]), .hf_osc_stable(st[0]),
    .ext_osc_tick(ev[0]), .ext_clk_fail(ev[2]),
    .wake_event(ev[1]), .sleep_event(ev[3]),
    .pll_enable(pll_enable), .clk_source(clk_source),
    .int_osc_id(int_osc_id), .int_freq_div_code(int_freq_div_code),
    .freq_trim(freq_trim));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bit aw;
    bit w;
    aw = 1;
    w = 1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_axi_awready) begin
        aw = 0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 0;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic pulse(input logic [3:0] m, input int n);
    repeat (n) begin
      @(posedge aclk);
      ev <= m;
      @(posedge aclk);
      ev <= 4'h0;
    end
  endtask
  function automatic logic [31:0] osc_of(input logic [3:0] c);
    if (c[3:1] == 3'h0) return 32'(OCC_OSC_LF);
    if (c[3] || c == 4'h3) return 32'(OCC_OSC_HF);
    return 32'(OCC_OSC_MF);
  endfunction
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      end_sim();
    end
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(OCC_ADDR_CONTROL);
    chk(rd, 32'h38);
    for (int i = 0; i < 4; i++) begin
      wr(OCC_ADDR_CONTROL, 8'h38 | 8'(i));
      @(posedge aclk);
      st <= PAT[i];
      rd_reg(OCC_ADDR_STATUS);
      chk(rd, {24'h0, ~PAT[i][7] | PAT[i][6], PAT[i][5], i == 0,
        PAT[i][4:0]});
      chk(32'(clk_source), i > 1 ? 32'h2 : 32'(i));
    end
    for (int c = 0; c < 16; c++) begin
      wr(OCC_ADDR_CONTROL, 8'(c << 3) | 8'h02);
      chk(32'(int_osc_id), osc_of(4'(c)));
      chk(32'(int_freq_div_code), 32'(c));
    end
    wr(OCC_ADDR_CONTROL, 8'h80);
    chk(32'(pll_enable), 32'h1);
    wr(OCC_ADDR_CONTROL, 8'h00);
    chk(32'(pll_enable), 32'h0);
    @(posedge aclk);
    cfg_pll_force <= 1'b1;
    @(posedge aclk);
    chk(32'(pll_enable), 32'h1);
    wr(OCC_ADDR_CONTROL, 8'hff);
    chk(32'(br), 32'(OCC_RESP_OKAY));
    rd_reg(OCC_ADDR_CONTROL);
    chk(rd, 32'(OCC_CTL_WMASK));
    wr(OCC_ADDR_TUNING, 8'hff);
    rd_reg(OCC_ADDR_TUNING);
    chk(rd, 32'h3f);
    wr(OCC_ADDR_TUNING, 8'h20);
    @(posedge aclk);
    chk(32'(freq_trim), 32'h20);
    wr(4'hc, 8'hff);
    chk(32'(br), 32'(OCC_RESP_SLVERR));
    rd_reg(4'hc);
    chk(rd, 32'h0);
    chk(32'(rr), 32'(OCC_RESP_SLVERR));
    @(posedge aclk);
    cfg_crystal_mode <= 1'b1;
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    pulse(4'h1, 3);
    pulse(4'h2, 1);
    pulse(4'h1, 3);
    chk(32'(clk_source), 32'(OCC_SRC_INT));
    pulse(4'h1, 1);
    repeat (3) @(posedge aclk);
    chk(32'(clk_source), 32'(OCC_SRC_CFG));
    // The fallback must follow the code written now, not the reset code.
    wr(OCC_ADDR_CONTROL, 8'h68);
    pulse(4'h4, 1);
    repeat (2) @(posedge aclk);
    chk(32'(clk_source), 32'(OCC_SRC_INT));
    chk(32'(int_osc_id), 32'(OCC_OSC_HF));
    chk(32'(int_freq_div_code), 32'h0000000d);
    pulse(4'h8, 1);
    pulse(4'h1, 4);
    repeat (2) @(posedge aclk);
    chk(32'(clk_source), 32'(OCC_SRC_CFG));
    end_sim();
  end
endmodule

// >>> include/occ_pkg.sv
package occ_pkg;
  // Register byte addresses.
  localparam logic [3:0] OCC_ADDR_CONTROL = 4'h0;
  localparam logic [3:0] OCC_ADDR_STATUS = 4'h4;
  localparam logic [3:0] OCC_ADDR_TUNING = 4'h8;
  // Control register fields.
  localparam int OCC_CTL_PLL_BIT = 7;
  localparam int OCC_CTL_IFS_LSB = 3;
  localparam int OCC_CTL_SCS_LSB = 0;
  localparam logic [7:0] OCC_CTL_WMASK = 8'hfb;
  // Reset values.
  localparam logic [3:0] OCC_IFS_RESET = 4'h7;
  localparam logic [1:0] OCC_SCS_RESET = 2'h0;
  localparam logic [5:0] OCC_TRIM_RESET = 6'h00;
  localparam logic OCC_PLL_RESET = 1'b0;
  // Start-up timer length in oscillator cycles.
  localparam int OCC_OST_CYCLES = 1024;
  // Clock source choices.
  localparam logic [1:0] OCC_SRC_CFG = 2'h0;
  localparam logic [1:0] OCC_SRC_SEC = 2'h1;
  localparam logic [1:0] OCC_SRC_INT = 2'h2;
  // Oscillator ids used for the selected internal source.
  localparam logic [1:0] OCC_OSC_LF = 2'h0;
  localparam logic [1:0] OCC_OSC_MF = 2'h1;
  localparam logic [1:0] OCC_OSC_HF = 2'h2;
  // AXI responses.
  localparam logic [1:0] OCC_RESP_OKAY = 2'h0;
  localparam logic [1:0] OCC_RESP_SLVERR = 2'h2;
endpackage

// >>> src/occ_osc_ctrl.sv
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module occ_osc_ctrl
  import occ_pkg::*;
#(
  parameter int OST_COUNT = OCC_OST_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Configuration word
  input wire logic cfg_pll_force,
  input wire logic [2:0] cfg_osc_mode,
  input wire logic cfg_crystal_mode,
  // Oscillator status inputs
  input wire logic sec_osc_enable,
  input wire logic sec_osc_raw_ready,
  input wire logic pll_ready,
  input wire logic hf_osc_ready,
  input wire logic hf_osc_locked,
  input wire logic mf_osc_ready,
  input wire logic lf_osc_ready,
  input wire logic hf_osc_stable,
  // External oscillator events
  input wire logic ext_osc_tick,
  input wire logic ext_clk_fail,
  input wire logic wake_event,
  input wire logic sleep_event,
  // Clock controls
  output logic pll_enable,
  output logic [1:0] clk_source,
  output logic [1:0] int_osc_id,
  output logic [3:0] int_freq_div_code,
  output logic [5:0] freq_trim
);
  typedef enum logic [2:0] {
    OCC_ST_INT = 3'b001,
    OCC_ST_EXT = 3'b010,
    OCC_ST_FAIL = 3'b100
  } occ_src_e;

  logic sw_pll_enable_ff;
  logic [3:0] int_freq_select_ff;
  logic [1:0] sys_clk_select_ff;
  logic [5:0] freq_trim_ff;
  occ_src_e state_ff;
  occ_src_e nxt_state;
  logic ost_restart;
  logic ost_done;
  logic scs_write;
  logic [1:0] nxt_scs;

  // Write and read channel latches.
  logic aw_ff;
  logic w_ff;
  logic [3:0] awaddr_ff;
  logic [7:0] wdata_ff;
  logic wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic wr_go;
  logic [7:0] rd_val;
  logic rd_ok;
  logic [7:0] status_val;
  logic [7:0] control_val;

  assign s_axi_awready = !aw_ff && !bvalid_ff;
  assign s_axi_wready = !w_ff && !bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign wr_go = aw_ff && w_ff && !bvalid_ff;

  // Address and data may arrive in either order; each is held until both.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff <= 1'b0;
      awaddr_ff <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_ff <= 1'b0;
      wdata_ff <= 8'h00;
      wstrb_ff <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_ff <= 1'b1;
      wdata_ff <= s_axi_wdata[7:0];
      wstrb_ff <= s_axi_wstrb[0];
    end else if (wr_go) begin
      w_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= OCC_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= (awaddr_ff == OCC_ADDR_CONTROL ||
                   awaddr_ff == OCC_ADDR_STATUS ||
                   awaddr_ff == OCC_ADDR_TUNING) ?
                  OCC_RESP_OKAY : OCC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign scs_write = wr_go && wstrb_ff && awaddr_ff == OCC_ADDR_CONTROL;
  assign nxt_scs = wdata_ff[OCC_CTL_SCS_LSB +: 2];

  // Control register; bit 2 is never stored.
  // reset frequency code
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_pll_enable_ff <= OCC_PLL_RESET;
      int_freq_select_ff <= OCC_IFS_RESET;
      sys_clk_select_ff <= OCC_SCS_RESET;
    end else if (scs_write) begin
      sw_pll_enable_ff <= wdata_ff[OCC_CTL_PLL_BIT];
      int_freq_select_ff <= wdata_ff[OCC_CTL_IFS_LSB +: 4];
      sys_clk_select_ff <= nxt_scs;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      freq_trim_ff <= OCC_TRIM_RESET;
    end else if (wr_go && wstrb_ff && awaddr_ff == OCC_ADDR_TUNING) begin
      freq_trim_ff <= wdata_ff[5:0];
    end
  end
  assign freq_trim = freq_trim_ff;

  // start-up timer restarts on wake, sleep or a clock select change.
  assign ost_restart = wake_event || sleep_event ||
                       (scs_write && nxt_scs != sys_clk_select_ff);

  occ_ost_counter #(
    .COUNT(OST_COUNT)
  ) u_ost (
    .aclk(aclk),
    .aresetn(aresetn),
    .restart(ost_restart),
    .tick(ext_osc_tick),
    .done(ost_done)
  );

  // Source state for the configured clock; a sleep aborts the start-up.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      OCC_ST_INT: begin
        if (!cfg_crystal_mode || (ost_done && !ost_restart)) begin
          nxt_state = OCC_ST_EXT;
        end
      end
      OCC_ST_EXT: begin
        if (ext_clk_fail) begin
          nxt_state = OCC_ST_FAIL;
        end else if (ost_restart && cfg_crystal_mode) begin
          nxt_state = OCC_ST_INT;
        end
      end
      OCC_ST_FAIL: begin
        if (ost_restart) begin
          nxt_state = OCC_ST_INT;
        end
      end
      default: nxt_state = OCC_ST_INT;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= OCC_ST_INT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign pll_enable = cfg_pll_force | sw_pll_enable_ff;

  always_comb begin
    if (sys_clk_select_ff[1]) begin
      clk_source = OCC_SRC_INT;
    end else if (sys_clk_select_ff[0]) begin
      clk_source = OCC_SRC_SEC;
    end else if (state_ff == OCC_ST_EXT) begin
      clk_source = OCC_SRC_CFG;
    end else begin
      clk_source = OCC_SRC_INT;
    end
  end

  always_comb begin
    int_freq_div_code = int_freq_select_ff;
    case (int_freq_select_ff)
      4'h0, 4'h1: int_osc_id = OCC_OSC_LF;
      4'h2, 4'h4, 4'h5, 4'h6, 4'h7: int_osc_id = OCC_OSC_MF;
      default: int_osc_id = OCC_OSC_HF;
    endcase
  end

  assign status_val = {
    (!sec_osc_enable) | sec_osc_raw_ready,
    pll_ready,
    clk_source == OCC_SRC_CFG,
    hf_osc_ready,
    hf_osc_locked,
    mf_osc_ready,
    lf_osc_ready,
    hf_osc_stable
  };

  assign control_val = {sw_pll_enable_ff, int_freq_select_ff, 1'b0,
                        sys_clk_select_ff};

  always_comb begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      OCC_ADDR_CONTROL: rd_val = control_val;
      OCC_ADDR_STATUS: rd_val = status_val;
      OCC_ADDR_TUNING: rd_val = {2'h0, freq_trim_ff};
      default: begin
        rd_val = 8'h00;
        rd_ok = 1'b0;
      end
    endcase
  end

  // Reads answer one cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= OCC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= {24'h0, rd_val};
      rresp_ff <= rd_ok ? OCC_RESP_OKAY : OCC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
endmodule

// >>> src/occ_ost_counter.sv
`timescale 1ns/1ps
// Counts edges of the external oscillator, seen as a synchronous tick.
module occ_ost_counter
  import occ_pkg::*;
#(
  parameter int COUNT = OCC_OST_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic restart,
  input wire logic tick,
  // Status
  output logic done
);
  localparam int W = $clog2(COUNT + 1);
  logic [W-1:0] count_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn || restart) begin
      count_ff <= '0;
    end else if (tick && count_ff != W'(COUNT)) begin
      count_ff <= count_ff + W'(1);
    end
  end

  assign done = (count_ff == W'(COUNT));
endmodule
